// file: verilog/csc_pkg.sv
// csc_pkg: constants, types and helpers of the climate stage control
// assumes a 20 MHz bus clock and a one-second tick from a system timer
package csc_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int KICK_S = 4;
	localparam int KICK_CYC = KICK_S * CLK_HZ;
	localparam int GEST_MS = 500;
	localparam int GEST_CYC = GEST_MS * (CLK_HZ / 1000);
	localparam int ACK_MS = 1000;
	localparam int ACK_CYC = ACK_MS * (CLK_HZ / 1000);
	localparam int DAY_H = 24;
	localparam int DAY_TICKS = DAY_H * 3600;
	localparam int MIN_TICKS = 60;
	// register byte offsets
	localparam logic [7:0] A_SETP = 8'h00;
	localparam logic [7:0] A_FAN2 = 8'h04;
	localparam logic [7:0] A_STG3 = 8'h08;
	localparam logic [7:0] A_RAMP = 8'h0C;
	localparam logic [7:0] A_FAN1 = 8'h10;
	localparam logic [7:0] A_ALRM = 8'h14;
	localparam logic [7:0] A_SENS = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1C;
	localparam logic [7:0] A_RECS = 8'h20;
	localparam logic [7:0] A_DISP = 8'h24;
	// field positions
	localparam int F2_CRV = 8;
	localparam int F2_RSP = 16;
	localparam int F2_BND = 24;
	localparam int S3_DIF = 8;
	localparam int RP_MIN = 8;
	localparam int F1_HMN = 8;
	localparam int F1_PER = 16;
	localparam int F1_DUT = 24;
	localparam int F1_CRV = 29;
	localparam int AL_MIN = 8;
	localparam int SN_HUM = 16;
	localparam int SN_OK = 24;
	// temperatures in hundredths, settings in native steps
	typedef logic signed [15:0] csc_tmp_t;
	localparam csc_tmp_t SP_LO = -16'sd19;
	localparam csc_tmp_t SP_HI = 16'sd82;
	localparam csc_tmp_t S3_LO = -16'sd10;
	localparam csc_tmp_t S3_HI = 16'sd20;
	localparam csc_tmp_t DF_LO = 16'sd1;
	localparam csc_tmp_t DF_HI = 16'sd6;
	localparam csc_tmp_t RD_HI = 16'sd50;
	localparam csc_tmp_t HM_LO = 16'sd30;
	localparam csc_tmp_t HM_HI = 16'sd80;
	localparam csc_tmp_t SD_LO = 16'sd12;
	localparam csc_tmp_t SD_HI = 16'sd100;
	localparam csc_tmp_t PR_LO = 16'sd1;
	localparam csc_tmp_t PR_HI = 16'sd10;
	localparam csc_tmp_t DU_HI = 16'sd20;
	localparam csc_tmp_t AL_LO = -16'sd36;
	localparam csc_tmp_t AL_HI = 16'sd0;
	localparam csc_tmp_t F2B_LO = 16'sd2;
	localparam csc_tmp_t HALF_S = 16'sd50;
	localparam csc_tmp_t T_LO = -16'sd1000;
	localparam csc_tmp_t T_HI = 16'sd4100;
	localparam csc_tmp_t R_HI = 16'sd4050;
	localparam int HALF = 50;
	localparam int ROFS = 5000;
	localparam int DU_SEC = MIN_TICKS / 20;
	localparam logic [6:0] HUM_BAND = 7'h0A;
	localparam logic [6:0] FULL7 = 7'h64;
	// reset values
	localparam csc_tmp_t RST_SP = 16'sd2500;
	localparam logic [6:0] RST_SPD = 7'h18;
	localparam logic [6:0] RST_HUM = 7'h50;
	// display marks and selector positions
	localparam logic [1:0] MK_NONE = 2'h0;
	localparam logic [1:0] MK_UND = 2'h1;
	localparam logic [1:0] MK_OVR = 2'h2;
	localparam logic [1:0] MK_ACK = 2'h3;
	localparam logic [3:0] POS_SP = 4'h1;
	localparam logic [3:0] POS_LOW = 4'hA;
	localparam logic [3:0] POS_HIGH = 4'hB;
	localparam logic [3:0] POS_ROOM = 4'hC;
	typedef enum logic [2:0] {
		G_IDLE = 3'b001,
		G_CCW = 3'b010,
		G_CW = 3'b100
	} csc_gest_t;
	function automatic csc_tmp_t csc_clamp(csc_tmp_t v, csc_tmp_t lo,
		csc_tmp_t hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	// nearest half degree
	function automatic csc_tmp_t csc_near(csc_tmp_t v);
		int t;
		t = int'(v) + ROFS + HALF / 2;
		return csc_tmp_t'((t / HALF) * HALF - ROFS);
	endfunction
	// next half degree upward
	function automatic csc_tmp_t csc_up(csc_tmp_t v);
		int t;
		t = int'(v) + ROFS + HALF - 1;
		return csc_tmp_t'((t / HALF) * HALF - ROFS);
	endfunction
endpackage

// file: verilog/csc_stage_ctrl.sv
// csc_stage_ctrl: settings, ramp, records, display and stage decisions
// assumes an AHB-Lite master, synchronous panel pulses and a 1 s tick
// Function
// - fan two at minimum speed at relative point
// - fan two full speed four seconds after start
// - stage three offset -5.0 to +10.0 half-steps
// - stage three on at set point plus offset
// - ramp subtracts daily reduction every day
// - daily reduction off or 0.01 to 0.50
// - manual set point ignored while ramping
// - reaching ramp floor turns reduction off
// - ramped set point shown by half-degree crossings
// - record low nearest half, under mark below -10
// - record high rounded up, over mark above 40.5
// - counter-clockwise then clockwise gesture at record clears, shows acknowledge
// - room display -10.0 to 41.0 with marks
// - humidity raises fan one minimum over band
// - humidity set point 30 to 80 percent
// - eight motor curves per fan
// - humidity minimum speed 12 to 100 even
// - fan one period 1 to 10 minutes
// - stage three hysteresis differential 0.5 to 3
// - ramp floor -9.5 to 41.0 half-steps
// - low alarm below set point plus offset
// - room-position gesture enters secondary mode
// - main set point -9.5 to 41.0 half-steps
// - fan one duty cycle below set point
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module csc_stage_ctrl #(
	parameter int KICK_N = csc_pkg::KICK_CYC,
	parameter int GEST_N = csc_pkg::GEST_CYC,
	parameter int ACK_N = csc_pkg::ACK_CYC,
	parameter int DAY_N = csc_pkg::DAY_TICKS
) (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input logic tick_1s,
	input logic [3:0] sel_pos,
	input logic adj_cw,
	input logic adj_ccw,
	output logic [6:0] fan1_min_speed,
	output logic fan1_on,
	output logic [2:0] fan1_curve,
	output logic [6:0] fan2_speed,
	output logic [2:0] fan2_curve,
	output logic stage3_on,
	output logic alarm_contact,
	output logic alarm_led,
	output logic signed [15:0] disp_val,
	output logic [1:0] disp_mark,
	output logic sec_mode
);
	logic wr_r, hrdy_r;
	logic [7:0] wa_r;
	logic [31:0] hrdata_r, rd_mux;
	logic signed [15:0] sp_r, temp_r, low_r, high_r, sp_nxt;
	logic signed [7:0] s3off_r, rmin_r, alm_r;
	logic [6:0] f2min_r, f1min_r, hmin_r, humsp_r, hum_r;
	logic [4:0] f2rsp_r, f2band_r, duty_r;
	logic [5:0] red_r, red_nxt;
	logic [3:0] per_r, sel_prev_r;
	logic [2:0] f1crv_r, f2crv_r, s3dif_r;
	logic hum_ok_r, s3_r, alarm_r, sec_r, kick_r;
	logic [26:0] kick_cnt_r;
	logic [16:0] day_cnt_r;
	logic [9:0] dc_cnt_r;
	logic [24:0] g_cnt_r, ack_cnt_r;
	logic [6:0] f2spd_r, f1min_eff_r;
	logic f1on_r;
	logic signed [15:0] dval_r;
	logic [1:0] dmark_r;
	csc_pkg::csc_gest_t g_r, g_nxt;

	// address phase capture; zero-wait slave, always OKAY
	wire a_ok = hsel & hready & htrans[1];
	wire hit = (haddr[31:8] == 24'h0);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			wa_r <= 8'h00;
			hrdata_r <= 32'h0;
			hrdy_r <= 1'b0;
		end else begin
			wr_r <= a_ok & hwrite & hit;
			wa_r <= haddr[7:0];
			hrdata_r <= (a_ok & ~hwrite & hit) ? rd_mux : 32'h0;
			hrdy_r <= 1'b1;
		end
	end

	// write strobes of the data phase
	wire w_sp = wr_r & (wa_r == csc_pkg::A_SETP);
	wire w_f2 = wr_r & (wa_r == csc_pkg::A_FAN2);
	wire w_s3 = wr_r & (wa_r == csc_pkg::A_STG3);
	wire w_rp = wr_r & (wa_r == csc_pkg::A_RAMP);
	wire w_f1 = wr_r & (wa_r == csc_pkg::A_FAN1);
	wire w_al = wr_r & (wa_r == csc_pkg::A_ALRM);
	wire w_sn = wr_r & (wa_r == csc_pkg::A_SENS);

	// clamped write values, in native steps
	wire signed [15:0] c_sp = csc_pkg::csc_clamp({{8{hwdata[7]}},
		hwdata[7:0]}, csc_pkg::SP_LO, csc_pkg::SP_HI);
	wire signed [15:0] c_s3 = csc_pkg::csc_clamp({{8{hwdata[7]}},
		hwdata[7:0]}, csc_pkg::S3_LO, csc_pkg::S3_HI);
	wire signed [15:0] c_df = csc_pkg::csc_clamp({13'h0,
		hwdata[csc_pkg::S3_DIF +: 3]}, csc_pkg::DF_LO,
		csc_pkg::DF_HI);
	wire signed [15:0] c_rd = csc_pkg::csc_clamp({10'h0, hwdata[5:0]},
		16'sd0, csc_pkg::RD_HI);
	wire signed [15:0] c_rm = csc_pkg::csc_clamp({{8{hwdata[15]}},
		hwdata[15:8]}, csc_pkg::SP_LO, csc_pkg::SP_HI);
	wire signed [15:0] c_hs = csc_pkg::csc_clamp({9'h0, hwdata[6:0]},
		csc_pkg::HM_LO, csc_pkg::HM_HI);
	wire signed [15:0] c_hm = csc_pkg::csc_clamp({9'h0,
		hwdata[csc_pkg::F1_HMN +: 7]}, csc_pkg::SD_LO,
		csc_pkg::SD_HI);
	wire signed [15:0] c_pr = csc_pkg::csc_clamp({12'h0,
		hwdata[csc_pkg::F1_PER +: 4]}, csc_pkg::PR_LO,
		csc_pkg::PR_HI);
	wire signed [15:0] c_du = csc_pkg::csc_clamp({11'h0,
		hwdata[csc_pkg::F1_DUT +: 5]}, 16'sd0, csc_pkg::DU_HI);
	wire signed [15:0] c_f2 = csc_pkg::csc_clamp({9'h0, hwdata[6:0]},
		csc_pkg::SD_LO, csc_pkg::SD_HI);
	wire signed [15:0] c_f1 = csc_pkg::csc_clamp({9'h0,
		hwdata[csc_pkg::AL_MIN +: 7]}, csc_pkg::SD_LO, csc_pkg::SD_HI);
	wire signed [15:0] c_al = csc_pkg::csc_clamp({{8{hwdata[7]}},
		hwdata[7:0]}, csc_pkg::AL_LO, csc_pkg::AL_HI);
	wire signed [15:0] c_rs = csc_pkg::csc_clamp({11'h0,
		hwdata[csc_pkg::F2_RSP +: 5]}, 16'sd0, csc_pkg::S3_HI);
	wire signed [15:0] c_bd = csc_pkg::csc_clamp({11'h0,
		hwdata[csc_pkg::F2_BND +: 5]}, csc_pkg::F2B_LO, csc_pkg::S3_HI);

	// settings held by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			f2min_r <= csc_pkg::RST_SPD;
			f2crv_r <= 3'h0;
			f2rsp_r <= 5'h00;
			f2band_r <= 5'h02;
			s3off_r <= 8'h00;
			s3dif_r <= 3'h1;
			rmin_r <= 8'hED;
			humsp_r <= csc_pkg::RST_HUM;
			hmin_r <= csc_pkg::RST_SPD;
			per_r <= 4'h1;
			duty_r <= 5'h14;
			f1crv_r <= 3'h0;
			alm_r <= 8'hDC;
			f1min_r <= csc_pkg::RST_SPD;
			temp_r <= csc_pkg::RST_SP;
			hum_r <= 7'h00;
			hum_ok_r <= 1'b0;
		end else begin
			if (w_f2) begin
				f2min_r <= c_f2[6:0] & 7'h7E;
				f2crv_r <= hwdata[csc_pkg::F2_CRV +: 3];
				f2rsp_r <= c_rs[4:0];
				f2band_r <= c_bd[4:0];
			end
			if (w_s3) begin
				s3off_r <= c_s3[7:0];
				s3dif_r <= c_df[2:0];
			end
			if (w_rp)
				rmin_r <= c_rm[7:0];
			if (w_f1) begin
				humsp_r <= c_hs[6:0];
				hmin_r <= c_hm[6:0] & 7'h7E;
				per_r <= c_pr[3:0];
				duty_r <= c_du[4:0];
				f1crv_r <= hwdata[csc_pkg::F1_CRV +: 3];
			end
			if (w_al) begin
				alm_r <= c_al[7:0];
				f1min_r <= c_f1[6:0] & 7'h7E;
			end
			if (w_sn) begin
				temp_r <= hwdata[15:0];
				hum_r <= hwdata[csc_pkg::SN_HUM +: 7];
				hum_ok_r <= hwdata[csc_pkg::SN_OK];
			end
		end
	end

	// daily ramp of the main set point
	wire ramp_en = (red_r != 6'h00);
	wire ramp_step = ramp_en & tick_1s &
		(day_cnt_r == 17'(DAY_N - 1));
	wire signed [15:0] rmin_h = rmin_r * csc_pkg::HALF_S;
	wire signed [15:0] ramp_sp = sp_r - $signed({10'h0, red_r});
	wire ramp_floor = ramp_step & (ramp_sp <= rmin_h);
	assign sp_nxt = (w_sp & ~ramp_en) ? c_sp * csc_pkg::HALF_S :
		ramp_floor ? rmin_h :
		ramp_step ? ramp_sp : sp_r;
	assign red_nxt = ramp_floor ? 6'h00 :
		w_rp ? c_rd[5:0] : red_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_r <= csc_pkg::RST_SP;
			red_r <= 6'h00;
			day_cnt_r <= 17'h0;
		end else begin
			sp_r <= sp_nxt;
			red_r <= red_nxt;
			if (!ramp_en || ramp_step)
				day_cnt_r <= 17'h0;
			else if (tick_1s)
				day_cnt_r <= day_cnt_r + 17'h1;
		end
	end

	// fan two speed with start-up kick
	wire signed [15:0] f2r_h = $signed({11'h0, f2rsp_r}) * csc_pkg::HALF_S;
	wire signed [15:0] f2b_h = $signed({11'h0, f2band_r}) * csc_pkg::HALF_S;
	wire signed [15:0] f2_d = temp_r - sp_r - f2r_h;
	wire [31:0] f2_num = 32'(csc_pkg::FULL7 - f2min_r) * 32'(f2_d);
	wire [6:0] f2_calc = (f2_d < 16'sd0) ? 7'h00 :
		(f2_d >= f2b_h) ? csc_pkg::FULL7 :
		7'(f2min_r + 7'(f2_num / 32'(f2b_h)));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			kick_cnt_r <= 27'h0;
			kick_r <= 1'b1;
			f2spd_r <= 7'h00;
		end else begin
			if (kick_r)
				kick_cnt_r <= kick_cnt_r + 27'h1;
			kick_r <= kick_r & (kick_cnt_r < 27'(KICK_N - 1));
			f2spd_r <= kick_r ? csc_pkg::FULL7 : f2_calc;
		end
	end

	// fan one humidity boost and duty cycle
	wire signed [7:0] hd = $signed({1'b0, hum_r}) - $signed({1'b0, humsp_r});
	wire [15:0] f1_num = 16'(hmin_r - f1min_r) * 16'(hd[6:0]);
	wire [6:0] f1_calc = (!hum_ok_r || hd <= 8'sd0 || hmin_r <= f1min_r) ?
		f1min_r : (hd >= $signed({1'b0, csc_pkg::HUM_BAND})) ? hmin_r :
		7'(f1min_r + 7'(f1_num / 16'(csc_pkg::HUM_BAND)));
	wire [9:0] per_s = 10'(per_r * csc_pkg::MIN_TICKS);
	wire [9:0] on_s = 10'(duty_r * per_r * csc_pkg::DU_SEC);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dc_cnt_r <= 10'h0;
			f1on_r <= 1'b0;
			f1min_eff_r <= csc_pkg::RST_SPD;
		end else begin
			if (tick_1s)
				dc_cnt_r <= (dc_cnt_r >= per_s - 10'h1) ? 10'h0 :
					dc_cnt_r + 10'h1;
			f1on_r <= (temp_r >= sp_r) | (dc_cnt_r < on_s);
			f1min_eff_r <= f1_calc;
		end
	end

	// stage three hysteresis and low alarm
	wire signed [15:0] s3_thr = sp_r + s3off_r * csc_pkg::HALF_S;
	wire signed [15:0] s3_dh = $signed({13'h0, s3dif_r}) * csc_pkg::HALF_S;
	wire s3_heat = s3off_r[7];
	wire s3_nxt = s3_heat ?
		((temp_r <= s3_thr) | (s3_r & (temp_r < s3_thr + s3_dh))) :
		((temp_r >= s3_thr) | (s3_r & (temp_r > s3_thr - s3_dh)));
	wire signed [15:0] alm_thr = sp_r + alm_r * csc_pkg::HALF_S;
	wire alm_c = (temp_r < alm_thr);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s3_r <= 1'b0;
			alarm_r <= 1'b0;
		end else begin
			s3_r <= s3_nxt;
			alarm_r <= alm_c;
		end
	end

	// adjuster gesture recogniser
	wire g_to = (g_cnt_r == 25'h0);
	wire rev_a = (g_r == csc_pkg::G_CCW) & adj_cw & ~g_to;
	wire rev_b = (g_r == csc_pkg::G_CW) & adj_ccw & ~g_to;
	wire at_rec = (sel_pos == csc_pkg::POS_LOW) |
		(sel_pos == csc_pkg::POS_HIGH);
	wire at_room = (sel_pos == csc_pkg::POS_ROOM);
	wire clr_ev = rev_a & ~sec_r & at_rec;
	wire sec_ev = (rev_a | rev_b) & at_room & ~sec_r;
	always_comb begin
		g_nxt = g_r;
		case (g_r)
			csc_pkg::G_IDLE: begin
				if (adj_ccw)
					g_nxt = csc_pkg::G_CCW;
				else if (adj_cw)
					g_nxt = csc_pkg::G_CW;
			end
			csc_pkg::G_CCW: begin
				if (adj_cw || g_to)
					g_nxt = csc_pkg::G_IDLE;
			end
			csc_pkg::G_CW: begin
				if (adj_ccw || g_to)
					g_nxt = csc_pkg::G_IDLE;
			end
			default: g_nxt = csc_pkg::G_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			g_r <= csc_pkg::G_IDLE;
			g_cnt_r <= 25'h0;
			ack_cnt_r <= 25'h0;
			sec_r <= 1'b0;
			sel_prev_r <= 4'h0;
		end else begin
			g_r <= g_nxt;
			g_cnt_r <= (adj_cw | adj_ccw) ? 25'(GEST_N) :
				g_to ? 25'h0 : g_cnt_r - 25'h1;
			ack_cnt_r <= clr_ev ? 25'(ACK_N) :
				(ack_cnt_r == 25'h0) ? 25'h0 : ack_cnt_r - 25'h1;
			sec_r <= sec_ev | (sec_r & ~(at_room &
				(sel_prev_r != csc_pkg::POS_ROOM)));
			sel_prev_r <= sel_pos;
		end
	end

	// record low and high since last clear
	wire clr_lo = clr_ev & (sel_pos == csc_pkg::POS_LOW);
	wire clr_hi = clr_ev & (sel_pos == csc_pkg::POS_HIGH);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_r <= 16'sh7FFF;
			high_r <= 16'sh8000;
		end else begin
			low_r <= (clr_lo || temp_r < low_r) ? temp_r : low_r;
			high_r <= (clr_hi || temp_r > high_r) ? temp_r : high_r;
		end
	end

	// display value and mark selection
	wire [3:0] psel = sec_r ? csc_pkg::POS_ROOM : sel_pos;
	wire room_u = (temp_r < csc_pkg::T_LO);
	wire room_o = (temp_r > csc_pkg::T_HI);
	wire signed [15:0] dv_nxt =
		(psel == csc_pkg::POS_SP) ? csc_pkg::csc_up(sp_r) :
		(psel == csc_pkg::POS_LOW) ? csc_pkg::csc_near(low_r) :
		(psel == csc_pkg::POS_HIGH) ? csc_pkg::csc_up(high_r) :
		csc_pkg::csc_near(temp_r);
	wire [1:0] dm_nxt = (ack_cnt_r != 25'h0) ? csc_pkg::MK_ACK :
		(psel == csc_pkg::POS_SP) ? csc_pkg::MK_NONE :
		(psel == csc_pkg::POS_LOW) ? ((low_r < csc_pkg::T_LO) ?
		csc_pkg::MK_UND : csc_pkg::MK_NONE) :
		(psel == csc_pkg::POS_HIGH) ? ((high_r > csc_pkg::R_HI) ?
		csc_pkg::MK_OVR : csc_pkg::MK_NONE) :
		room_u ? csc_pkg::MK_UND : room_o ? csc_pkg::MK_OVR :
		csc_pkg::MK_NONE;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dval_r <= 16'sh0000;
			dmark_r <= csc_pkg::MK_NONE;
		end else begin
			dval_r <= dv_nxt;
			dmark_r <= dm_nxt;
		end
	end

	// read data selection
	wire [7:0] ra = haddr[7:0];
	assign rd_mux = (ra == csc_pkg::A_SETP) ? {{16{sp_r[15]}}, sp_r} :
		(ra == csc_pkg::A_FAN2) ? {3'h0, f2band_r, 3'h0, f2rsp_r, 5'h0,
		f2crv_r, 1'h0, f2min_r} :
		(ra == csc_pkg::A_STG3) ? {21'h0, s3dif_r, s3off_r} :
		(ra == csc_pkg::A_RAMP) ? {16'h0, rmin_r, 2'h0, red_r} :
		(ra == csc_pkg::A_FAN1) ? {f1crv_r, duty_r, 4'h0, per_r, 1'h0,
		hmin_r, 1'h0, humsp_r} :
		(ra == csc_pkg::A_ALRM) ? {17'h0, f1min_r, alm_r} :
		(ra == csc_pkg::A_SENS) ? {7'h0, hum_ok_r, 1'h0, hum_r, temp_r} :
		(ra == csc_pkg::A_STAT) ? {16'h0, 1'h0, f2spd_r, 3'h0, kick_r,
		ramp_en, sec_r, alarm_r, s3_r} :
		(ra == csc_pkg::A_RECS) ? {high_r, low_r} :
		(ra == csc_pkg::A_DISP) ? {14'h0, dmark_r, dval_r} : 32'h0;

	// outputs straight from flip-flops, hresp tied low
	assign hrdata = hrdata_r;
	assign hreadyout = hrdy_r;
	assign hresp = 1'b0;
	assign fan1_min_speed = f1min_eff_r;
	assign fan1_on = f1on_r;
	assign fan1_curve = f1crv_r;
	assign fan2_speed = f2spd_r;
	assign fan2_curve = f2crv_r;
	assign stage3_on = s3_r;
	assign alarm_contact = alarm_r;
	assign alarm_led = alarm_r;
	assign disp_val = dval_r;
	assign disp_mark = dmark_r;
	assign sec_mode = sec_r;

	// checks on the decision logic
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// hrdy_r keeps the attempt at the release edge out, where the
	// output still holds its reset value
	property p_kick;
		(kick_r && hrdy_r) |=> f2spd_r == csc_pkg::FULL7;
	endproperty
	a_kick: assert property (p_kick) else $error("kick not full");
	property p_f2min;
		(!kick_r && f2_d == 16'sd0) |=> f2spd_r == $past(f2min_r);
	endproperty
	a_f2min: assert property (p_f2min) else $error("fan2 min");
	property p_hold;
		(ramp_en && w_sp && !ramp_step) |=> $stable(sp_r);
	endproperty
	a_hold: assert property (p_hold) else $error("manual sp");
	property p_ramp;
		(ramp_step && !ramp_floor) |=>
			sp_r == $past(sp_r) - $signed({10'h0, $past(red_r)});
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp step");
	property p_floor;
		ramp_floor |=> (red_r == 6'h00) && (sp_r == $past(rmin_h));
	endproperty
	a_floor: assert property (p_floor) else $error("ramp floor");
	property p_alarm;
		alm_c ##1 alm_c |=> alarm_r;
	endproperty
	a_alarm: assert property (p_alarm) else $error("low alarm");
	property p_heat;
		(s3_heat && temp_r <= s3_thr) |=> s3_r;
	endproperty
	a_heat: assert property (p_heat) else $error("heater on");
	property p_ack;
		clr_ev |=> ##1 dmark_r == csc_pkg::MK_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack mark");
	property p_sec;
		sec_ev |=> sec_r;
	endproperty
	a_sec: assert property (p_sec) else $error("no sec mode");
	c_ramp: cover property (ramp_floor);
	c_clr: cover property (clr_ev);
	c_sec: cover property (sec_ev);
endmodule

// file: testbench/tb_climate_stage_control.sv
// tb_climate_stage_control: register and panel bench for the stage control
// assumes the design answers with zero wait states and short count parameters
`timescale 1ns/10ps
module tb_climate_stage_control;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic tick_1s = 0, adj_cw = 0, adj_ccw = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] sel_pos = 4'h1;
	wire [31:0] hrdata;
	wire hreadyout, hresp, fan1_on, stage3_on, alarm_contact, alarm_led, sec_mode;
	wire [6:0] fan1_min_speed, fan2_speed;
	wire [2:0] fan1_curve, fan2_curve;
	wire signed [15:0] disp_val;
	wire [1:0] disp_mark;
	int err_total = 0, checks = 0;
	int i;
	int tv[8], ev[8];
	logic [31:0] sv[8];

	// short counts keep kick, gesture, acknowledge and day within the run
	csc_stage_ctrl #(.KICK_N(20), .GEST_N(8), .ACK_N(10), .DAY_N(3)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .tick_1s(tick_1s), .sel_pos(sel_pos), .adj_cw(adj_cw),
		.adj_ccw(adj_ccw), .fan1_min_speed(fan1_min_speed), .fan1_on(fan1_on),
		.fan1_curve(fan1_curve), .fan2_speed(fan2_speed),
		.fan2_curve(fan2_curve), .stage3_on(stage3_on),
		.alarm_contact(alarm_contact), .alarm_led(alarm_led),
		.disp_val(disp_val), .disp_mark(disp_mark), .sec_mode(sec_mode));

	// free running bus clock
	initial begin
		forever #25 hclk = ~hclk;
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// wait for hready at a rising edge, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 50) check("hready wait", 0, 1);
	endtask

	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic settle(int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic sens(int t, int hum, logic ok);
		bus(1'b1, csc_pkg::A_SENS, {7'h00, ok, 1'b0, 7'(hum), 16'(t)});
		settle(3);
	endtask

	task automatic pulse(logic cw);
		@(posedge hclk);
		if (cw) adj_cw <= 1'b1;
		else adj_ccw <= 1'b1;
		@(posedge hclk);
		adj_cw <= 1'b0;
		adj_ccw <= 1'b0;
	endtask

	task automatic ticks(int n);
		repeat (n) begin
			@(posedge hclk);
			tick_1s <= 1'b1;
			@(posedge hclk);
			tick_1s <= 1'b0;
		end
		settle(3);
	endtask

	// watchdog against a hung handshake
	initial begin
		#(50 * 20000);
		err_total++;
		test_done();
	end

	initial begin
		#1;
		check("reset hready", hreadyout, 0);
		check("reset fan2", fan2_speed, 0);
		check("okay resp", hresp, 1'b0);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		settle(2);
		check("kick fan2", fan2_speed, 7'h64);
		settle(25);
		check("fan2 after kick", fan2_speed, 7'h18);
		bus(1'b0, csc_pkg::A_SETP, 0);
		check("setp reset", rd, 32'h0000_09C4);
		bus(1'b0, csc_pkg::A_FAN1, 0);
		check("fan1 reset", rd, 32'h1401_1850);
		bus(1'b0, csc_pkg::A_ALRM, 0);
		check("alarm reset", rd[14:0], 15'h18DC);
		bus(1'b0, 8'hFC, 0);
		check("unmapped", rd, 0);
		$display("test reset done");
		// fan two proportional band, curve choice seven
		bus(1'b1, csc_pkg::A_FAN2, 32'h0200_0718);
		tv = '{2500, 2550, 2600, 2450, 0, 0, 0, 0};
		ev = '{24, 62, 100, 0, 0, 0, 0, 0};
		for (i = 0; i < 4; i++) begin
			sens(tv[i], 0, 1'b0);
			check("fan2 speed", fan2_speed, ev[i]);
		end
		check("fan2 curve", fan2_curve, 3'h7);
		$display("test fan2 done");
		// stage three as heater then as fan, with hysteresis
		sv = '{32'h2FE, 32'h2FE, 32'h2FE, 32'h2FE, 32'h2FE, 32'h102, 32'h102,
			32'h102};
		tv = '{2500, 2450, 2400, 2450, 2500, 2600, 2560, 2550};
		ev = '{0, 0, 1, 1, 0, 1, 1, 0};
		for (i = 0; i < 8; i++) begin
			bus(1'b1, csc_pkg::A_STG3, sv[i]);
			sens(tv[i], 0, 1'b0);
			check("stage3", stage3_on, ev[i][0]);
		end
		$display("test stage3 done");
		// low alarm at set point minus 18 degrees
		sens(699, 0, 1'b0);
		check("alarm on", {alarm_contact, alarm_led}, 2'h3);
		sens(700, 0, 1'b0);
		check("alarm off", {alarm_contact, alarm_led}, 2'h0);
		$display("test alarm done");
		// humidity boost of fan one minimum speed
		bus(1'b1, csc_pkg::A_FAN1, 32'hB401_321E);
		tv = '{35, 40, 30, 0, 0, 0, 0, 0};
		ev = '{37, 50, 24, 0, 0, 0, 0, 0};
		for (i = 0; i < 3; i++) begin
			sens(2500, tv[i], 1'b1);
			check("fan1 min", fan1_min_speed, ev[i]);
		end
		check("fan1 curve", fan1_curve, 3'h5);
		// half duty over a one-minute period while below set point
		bus(1'b1, csc_pkg::A_FAN1, 32'h0A01_321E);
		sens(2400, 0, 1'b0);
		check("fan1 on", fan1_on, 1'b1);
		ticks(30);
		check("fan1 off", fan1_on, 1'b0);
		ticks(30);
		check("fan1 on again", fan1_on, 1'b1);
		$display("test humidity done");
		// room display rounding and range marks
		sel_pos <= 4'hC;
		tv = '{2424, 2425, -1001, 4101, 4100, 0, 0, 0};
		ev = '{2400, 2450, 1, 2, 4100, 0, 0, 0};
		for (i = 0; i < 5; i++) begin
			sens(tv[i], 0, 1'b0);
			if (i == 2 || i == 3) check("room mark", disp_mark, ev[i]);
			else check("room value", disp_val, 16'(ev[i]));
		end
		$display("test display done");
		// records: low shown nearest, high over range, both cleared
		sens(1000, 0, 1'b0);
		sens(2000, 0, 1'b0);
		sel_pos <= 4'hA;
		settle(3);
		check("low shown", disp_val, -1000);
		check("low mark", disp_mark, 2'h1);
		pulse(1'b0);
		pulse(1'b1);
		settle(3);
		check("low ack", disp_mark, 2'h3);
		sel_pos <= 4'hB;
		settle(10);
		check("high mark", disp_mark, 2'h2);
		pulse(1'b0);
		pulse(1'b1);
		settle(3);
		bus(1'b0, csc_pkg::A_RECS, 0);
		check("records cleared", rd, {16'd2000, 16'd2000});
		check("high shown", disp_val, 16'd2000);
		$display("test records done");
		// secondary mode entry and exit
		sel_pos <= 4'hC;
		settle(3);
		pulse(1'b0);
		pulse(1'b1);
		settle(2);
		check("sec mode on", sec_mode, 1'b1);
		sel_pos <= 4'h1;
		settle(2);
		sel_pos <= 4'hC;
		settle(2);
		check("sec mode off", sec_mode, 1'b0);
		sel_pos <= 4'h1;
		$display("test secondary done");
		// daily ramp, manual lockout, shown value, floor
		bus(1'b1, csc_pkg::A_RAMP, 32'h0000_281E);
		ticks(3);
		bus(1'b1, csc_pkg::A_SETP, 32'h0000_003C);
		settle(2);
		bus(1'b0, csc_pkg::A_SETP, 0);
		check("ramped setp", rd, 32'h0000_09A6);
		check("setp shown", disp_val, 16'd2500);
		bus(1'b1, csc_pkg::A_RAMP, 32'h0000_311E);
		ticks(3);
		bus(1'b0, csc_pkg::A_SETP, 0);
		check("floor setp", rd, 32'h0000_0992);
		bus(1'b0, csc_pkg::A_RAMP, 0);
		check("reduction off", rd[5:0], 6'h00);
		$display("test ramp done");
		test_done();
	end
endmodule
